/* cat_map.svh */
// Offsets, field positions, opcodes and timing counts for the channel alert and termination block
`ifndef CAT_MAP_SVH
`define CAT_MAP_SVH
// Register offsets, one aligned word each
`define CAT_OFF_INT_COND 12'h000
`define CAT_OFF_DIAG 12'h004
`define CAT_OFF_MODE 12'h008
`define CAT_OFF_CTRL 12'h00C
`define CAT_OFF_WORD_LO 12'h010
`define CAT_OFF_WORD_HI 12'h014
`define CAT_OFF_STATUS 12'h018
`define CAT_OFF_COUNTER 12'h01C
// Interrupt-condition bit positions
`define CAT_IC_IO_CHECK 0
`define CAT_IC_SEQ_CHECK 1
`define CAT_IC_ABNORMAL 2
`define CAT_IC_ALERT1 3
`define CAT_IC_ALERT2 4
`define CAT_IC_IF_CHECK 5
// Mode status bit positions (word bit 29 is bit 6, word bit 35 is bit 0)
`define CAT_MODE_SELECT2 0
`define CAT_MODE_INH_ALERT2 1
`define CAT_MODE_INH_ALERT1 2
`define CAT_MODE_INH_ABNORMAL 3
// Word bit numbers, bit 0 is the sign (leftmost) position
`define CAT_WB_DIAG_FIRST 12
`define CAT_WB_S 0
`define CAT_WB_OP19 19
// Operation codes as captured {S,1,2,3,19}
`define CAT_OPC_READ 5'h01
`define CAT_OPC_WRITE 5'h02
`define CAT_OPC_CONTROL 5'h03
`define CAT_OPC_SENSE 5'h04
`define CAT_OPC_STOP 5'h05
`define CAT_OPC_LOAD_ASM 5'h06
`define CAT_OPC_STORE_ASM 5'h07
`define CAT_OPC_CMP_ASM 5'h08
`define CAT_OPC_MODE_SEL 5'h09
`define CAT_OPC_DIAG_STORE 5'h0A
`define CAT_OPC_STEP_CNT 5'h0B
`define CAT_OPC_INT_DONE 5'h0C
// Reset values
`define CAT_MODE_RESET 7'h00
// Timing: longest alert hold after ack, rounded down to cycles
`define CAT_CLK_NS 50
`define CAT_ALERT_DROP_NS 6000
`define CAT_ALERT_DROP_CYC (`CAT_ALERT_DROP_NS / `CAT_CLK_NS)
`endif

/* cat_pkg.sv */
// Types and shared helper functions for the channel alert and termination block
`include "cat_map.svh"
package cat_pkg;
   typedef enum logic [3:0] {
      OP_NONE, OP_READ, OP_WRITE, OP_CONTROL, OP_SENSE, OP_STOP, OP_LOAD_ASM,
      OP_STORE_ASM, OP_CMP_ASM, OP_MODE_SEL, OP_DIAG_STORE, OP_STEP_CNT, OP_INT_DONE
   } cat_op_t;

   // Word bit number to vector index, bit 0 is the leftmost
   function automatic logic [5:0] cat_wbit(input int n);
      cat_wbit = 6'(35 - n);
   endfunction

   // Odd parity over a six-bit character
   function automatic logic cat_odd_par(input logic [5:0] c);
      cat_odd_par = ~(^c);
   endfunction

   // Captured opcode to operation
   function automatic cat_op_t cat_decode(input logic [4:0] c);
      case (c)
         `CAT_OPC_READ: cat_decode = OP_READ;
         `CAT_OPC_WRITE: cat_decode = OP_WRITE;
         `CAT_OPC_CONTROL: cat_decode = OP_CONTROL;
         `CAT_OPC_SENSE: cat_decode = OP_SENSE;
         `CAT_OPC_STOP: cat_decode = OP_STOP;
         `CAT_OPC_LOAD_ASM: cat_decode = OP_LOAD_ASM;
         `CAT_OPC_STORE_ASM: cat_decode = OP_STORE_ASM;
         `CAT_OPC_CMP_ASM: cat_decode = OP_CMP_ASM;
         `CAT_OPC_MODE_SEL: cat_decode = OP_MODE_SEL;
         `CAT_OPC_DIAG_STORE: cat_decode = OP_DIAG_STORE;
         `CAT_OPC_STEP_CNT: cat_decode = OP_STEP_CNT;
         `CAT_OPC_INT_DONE: cat_decode = OP_INT_DONE;
         default: cat_decode = OP_NONE;
      endcase
   endfunction
endpackage

/* cat_if.sv */
// Link between the channel and the I-O adapter
`timescale 1ns/1ps
interface cat_if;
   logic operational;
   logic [3:0] cmd;
   logic cmd_ack;
   logic stop;
   logic svc_req;
   logic svc_resp;
   logic [8:0] write_bus;
   logic [8:0] read_bus;
   logic done_normal;
   logic done_abnormal;
   logic completion_ack;
   logic [1:0] device_alert;
   logic [1:0] alert_ack;

   modport channel (
      input operational, cmd_ack, svc_req, read_bus, done_normal, done_abnormal, device_alert,
      output cmd, stop, svc_resp, write_bus, completion_ack, alert_ack
   );
   modport adapter (
      output operational, cmd_ack, svc_req, read_bus, done_normal, done_abnormal, device_alert,
      input cmd, stop, svc_resp, write_bus, completion_ack, alert_ack
   );
endinterface

/* cat_alert_rcv.sv */
// One alert recognizer with its own latch and acknowledge
`timescale 1ns/1ps
`include "cat_map.svh"
module cat_alert_rcv (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic alert,
   input wire logic enable,
   output logic ack,
   output logic caught,
   output logic late
);
   logic [7:0] hold_q;

   // Catch and acknowledge; ack stays up until the alert has fallen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack <= 1'b0;
         caught <= 1'b0;
      end else begin
         caught <= 1'b0;
         if (!ack && alert && enable) begin
            ack <= 1'b1;
            caught <= 1'b1;
         end else if (ack && !alert) begin
            ack <= 1'b0;
         end
      end
   end

   // Flags an adapter that holds the alert past its allowed time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hold_q <= 8'h00;
         late <= 1'b0;
      end else begin
         late <= 1'b0;
         if (!(ack && alert)) begin
            hold_q <= 8'h00;
         end else if (hold_q != 8'(`CAT_ALERT_DROP_CYC)) begin
            hold_q <= hold_q + 8'h01;
            late <= (hold_q == 8'(`CAT_ALERT_DROP_CYC - 1));
         end
      end
   end
endmodule // cat_alert_rcv

/* cat_channel.sv */
// Channel end: APB registers, command termination, alerts, word and character buffers
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
`include "cat_map.svh"
module cat_channel (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   cat_if.channel lnk
);
   typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_RUN, ST_ACK} cat_state_t;

   cat_state_t state_q;
   cat_pkg::cat_op_t op_q;
   logic op_go_q;
   logic [4:0] opc_q;
   logic [35:0] word_q;
   logic [35:0] asm_q;
   logic [6:0] char_q;
   logic [2:0] ring_q;
   logic [5:0] ic_q;
   logic [6:0] mode_q;
   logic [14:0] cnt_q;
   logic [14:0] step_q;
   logic step_ph_q;
   logic cmp_hit_q;
   logic int_active_q;
   logic [1:0] kind_q;
   logic [3:0] cmd_q;
   logic stop_q;
   logic cack_q;
   logic resp_q;
   logic [8:0] wbus_q;
   logic par_err_q;
   logic [1:0] caught;
   logic [1:0] late;
   logic [1:0] alert_ack_w;
   logic [5:0] ic_set;
   logic [5:0] ic_clr;
   logic [4:0] diag;
   logic acc, wr_ok, ctl_go, reading, svc_take, io_op;

   // APB: one wait cycle, writes land on the edge that sees pready
   assign acc = psel & penable;
   assign wr_ok = acc & pready & pwrite;
   assign ctl_go = wr_ok & (paddr == `CAT_OFF_CTRL);
   assign reading = (kind_q == 2'd0) | (kind_q == 2'd3);
   assign svc_take = (state_q == ST_RUN) & lnk.svc_req & ~resp_q & ~stop_q;
   assign io_op = (op_q == cat_pkg::OP_READ) | (op_q == cat_pkg::OP_WRITE) |
                  (op_q == cat_pkg::OP_CONTROL) | (op_q == cat_pkg::OP_SENSE);

   // Link outputs straight from flops
   assign lnk.cmd = cmd_q;
   assign lnk.stop = stop_q;
   assign lnk.completion_ack = cack_q;
   assign lnk.svc_resp = resp_q;
   assign lnk.write_bus = wbus_q;
   assign lnk.alert_ack = alert_ack_w;

   // Diagnostic status lines, word bits 12 to 16 in order
   assign diag = {state_q == ST_CMD && reading, state_q == ST_CMD && !reading,
                  state_q == ST_RUN && reading, state_q == ST_RUN && !reading, int_active_q};

   // Two independent recognizers, never a shared latch
   for (genvar i = 0; i < 2; i++) begin : g_alert
      cat_alert_rcv u_rcv (
         .pclk(pclk),
         .presetn(presetn),
         .alert(lnk.device_alert[i]),
         .enable(lnk.operational & ~int_active_q),
         .ack(alert_ack_w[i]),
         .caught(caught[i]),
         .late(late[i])
      );
   end

   // Interrupt-condition sources; inhibit bits mask their causes
   always_comb begin
      ic_set = 6'h00;
      ic_set[`CAT_IC_IO_CHECK] = par_err_q;
      ic_set[`CAT_IC_SEQ_CHECK] = op_go_q & io_op & (state_q != ST_IDLE);
      ic_set[`CAT_IC_ABNORMAL] = (state_q == ST_RUN) & lnk.done_abnormal &
                                 ~mode_q[`CAT_MODE_INH_ABNORMAL];
      ic_set[`CAT_IC_ALERT1] = caught[0] & ~mode_q[`CAT_MODE_INH_ALERT1];
      ic_set[`CAT_IC_ALERT2] = caught[1] & ~mode_q[`CAT_MODE_INH_ALERT2];
      ic_set[`CAT_IC_IF_CHECK] = |late;
      ic_clr = (wr_ok && paddr == `CAT_OFF_INT_COND) ? pwdata[5:0] : 6'h00;
   end

   // Sticky conditions, write one to clear, a new event wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) ic_q <= 6'h00;
      else ic_q <= (ic_q & ~ic_clr) | ic_set;
   end

   // Interrupt program: started by an accepted alert, ended by its done command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) int_active_q <= 1'b0;
      else if (ic_set[`CAT_IC_ALERT1] || ic_set[`CAT_IC_ALERT2]) int_active_q <= 1'b1;
      else if (op_go_q && op_q == cat_pkg::OP_INT_DONE) int_active_q <= 1'b0;
   end

   // Operation decoder latch, executes on the following cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         opc_q <= 5'h00;
         op_q <= cat_pkg::OP_NONE;
         op_go_q <= 1'b0;
      end else begin
         op_go_q <= ctl_go;
         if (ctl_go) begin
            opc_q <= {word_q[cat_pkg::cat_wbit(`CAT_WB_S)], word_q[cat_pkg::cat_wbit(1)],
                      word_q[cat_pkg::cat_wbit(2)], word_q[cat_pkg::cat_wbit(3)],
                      word_q[cat_pkg::cat_wbit(`CAT_WB_OP19)]};
            op_q <= cat_pkg::cat_decode({word_q[cat_pkg::cat_wbit(`CAT_WB_S)], word_q[cat_pkg::cat_wbit(1)],
                      word_q[cat_pkg::cat_wbit(2)], word_q[cat_pkg::cat_wbit(3)],
                      word_q[cat_pkg::cat_wbit(`CAT_WB_OP19)]});
         end
      end
   end

   // Command and termination sequence
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= ST_IDLE;
         cmd_q <= 4'h0;
         kind_q <= 2'd0;
         stop_q <= 1'b0;
         cack_q <= 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (op_go_q && io_op) begin
                  kind_q <= 2'(op_q - cat_pkg::OP_READ);
                  cmd_q <= 4'h1 << (op_q - cat_pkg::OP_READ);
                  state_q <= ST_CMD;
               end
            end
            ST_CMD: begin
               if (lnk.cmd_ack) begin
                  cmd_q <= 4'h0;
                  state_q <= ST_RUN;
               end
            end
            ST_RUN: begin
               // Stop may not rise while a service exchange is fully up
               if (op_go_q && op_q == cat_pkg::OP_STOP && !(lnk.svc_req && resp_q)) stop_q <= 1'b1;
               if (lnk.done_normal || lnk.done_abnormal) begin
                  cack_q <= 1'b1;
                  state_q <= ST_ACK;
               end
            end
            ST_ACK: begin
               if (!lnk.cmd_ack && !lnk.done_normal && !lnk.done_abnormal) begin
                  cack_q <= 1'b0;
                  stop_q <= 1'b0;
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Service exchange with the character register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         resp_q <= 1'b0;
         char_q <= 7'h00;
         wbus_q <= 9'h000;
         par_err_q <= 1'b0;
      end else begin
         par_err_q <= 1'b0;
         if (svc_take) begin
            resp_q <= 1'b1;
            if (reading) begin
               char_q[5:0] <= lnk.read_bus[5:0];
               par_err_q <= lnk.read_bus[8] != cat_pkg::cat_odd_par(lnk.read_bus[5:0]);
            end else begin
               char_q <= {cat_pkg::cat_odd_par(asm_q[35:30]), asm_q[35:30]};
               wbus_q <= {cat_pkg::cat_odd_par(asm_q[35:30]), 2'b00, asm_q[35:30]};
            end
         end else if (!lnk.svc_req) begin
            resp_q <= 1'b0;
         end
      end
   end

   // Assembly register and character ring
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         asm_q <= 36'h0_0000_0000;
         ring_q <= 3'd0;
         cmp_hit_q <= 1'b0;
      end else if (svc_take) begin
         ring_q <= (ring_q == 3'd5) ? 3'd0 : ring_q + 3'd1;
         if (reading) asm_q <= {asm_q[29:0], lnk.read_bus[5:0]};
         else if (ring_q == 3'd5) asm_q <= word_q;
         else asm_q <= {asm_q[29:0], 6'h00};
      end else if (op_go_q) begin
         if (op_q == cat_pkg::OP_LOAD_ASM) begin
            asm_q <= word_q;
            ring_q <= 3'd0;
         end
         if (op_q == cat_pkg::OP_CMP_ASM) cmp_hit_q <= (asm_q & word_q) == word_q;
      end
   end

   // Word buffer: software, storing commands and completed read words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word_q <= 36'h0_0000_0000;
      end else if (svc_take && reading && ring_q == 3'd5) begin
         word_q <= {asm_q[29:0], lnk.read_bus[5:0]};
      end else if (op_go_q && op_q == cat_pkg::OP_STORE_ASM) begin
         word_q <= asm_q;
      end else if (op_go_q && op_q == cat_pkg::OP_DIAG_STORE) begin
         word_q[cat_pkg::cat_wbit(`CAT_WB_DIAG_FIRST) -: 5] <= diag;
      end else if (wr_ok && paddr == `CAT_OFF_WORD_LO) begin
         word_q[31:0] <= pwdata;
      end else if (wr_ok && paddr == `CAT_OFF_WORD_HI) begin
         word_q[35:32] <= pwdata[3:0];
      end
   end

   // Mode status from software or the mode select command
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) mode_q <= `CAT_MODE_RESET;
      else if (op_go_q && op_q == cat_pkg::OP_MODE_SEL) mode_q <= word_q[6:0];
      else if (wr_ok && paddr == `CAT_OFF_MODE) mode_q <= pwdata[6:0];
   end

   // Counter steps via the buffer: increment and clear in one cycle, then reload
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 15'h0000;
         step_q <= 15'h0000;
         step_ph_q <= 1'b0;
      end else if (step_ph_q) begin
         cnt_q <= step_q;
         step_ph_q <= 1'b0;
      end else if (op_go_q && op_q == cat_pkg::OP_STEP_CNT) begin
         step_q <= cnt_q + 15'h0001;
         cnt_q <= 15'h0000;
         step_ph_q <= 1'b1;
      end else if (wr_ok && paddr == `CAT_OFF_COUNTER) begin
         cnt_q <= pwdata[14:0];
      end
   end

   // Read data and error, registered during the wait cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= acc & ~pready;
         pslverr <= 1'b0;
         if (acc && !pready) begin
            case (paddr)
               `CAT_OFF_INT_COND: prdata <= {26'h000_0000, ic_q};
               `CAT_OFF_DIAG: prdata <= {27'h000_0000, diag};
               `CAT_OFF_MODE: prdata <= {25'h000_0000, mode_q};
               `CAT_OFF_CTRL: prdata <= {27'h000_0000, opc_q};
               `CAT_OFF_WORD_LO: prdata <= word_q[31:0];
               `CAT_OFF_WORD_HI: prdata <= {28'h000_0000, word_q[35:32]};
               `CAT_OFF_STATUS: prdata <= {16'h0000, char_q, cmp_hit_q, int_active_q, stop_q, cack_q,
                                           ring_q, state_q};
               `CAT_OFF_COUNTER: prdata <= {17'h0_0000, cnt_q};
               default: begin
                  prdata <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule // cat_channel

/* cat_adapter.sv */
// Adapter end: answers commands, serves characters, raises alerts and completions
`timescale 1ns/1ps
`include "cat_map.svh"
module cat_adapter (
   input wire logic pclk,
   input wire logic presetn,
   cat_if.adapter lnk,
   input wire logic online,
   input wire logic finish_ok,
   input wire logic finish_bad,
   input wire logic svc_go,
   input wire logic [5:0] svc_data,
   input wire logic [1:0] alert_set,
   input wire logic cause_clear,
   output logic [3:0] op_kind,
   output logic [5:0] rx_char,
   output logic [1:0] alert_cause
);
   logic cmd_ack_q, svc_req_q, done_n_q, done_a_q, oper_q, pend_ok_q, pend_bad_q;
   logic [8:0] rbus_q;
   logic [1:0] alert_q, pend_q;

   assign lnk.operational = oper_q;
   assign lnk.cmd_ack = cmd_ack_q;
   assign lnk.svc_req = svc_req_q;
   assign lnk.read_bus = rbus_q;
   assign lnk.done_normal = done_n_q;
   assign lnk.done_abnormal = done_a_q;
   assign lnk.device_alert = alert_q;

   // Command accept; completion ack returns us to ready
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         oper_q <= 1'b0;
         cmd_ack_q <= 1'b0;
         op_kind <= 4'h0;
      end else begin
         oper_q <= online;
         if (lnk.completion_ack) cmd_ack_q <= 1'b0;
         else if (|lnk.cmd && !cmd_ack_q && !done_n_q && !done_a_q) begin
            cmd_ack_q <= 1'b1;
            op_kind <= lnk.cmd;
         end
      end
   end

   // Completion: stop or user finish, never in mid exchange
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_ok_q <= 1'b0;
         pend_bad_q <= 1'b0;
         done_n_q <= 1'b0;
         done_a_q <= 1'b0;
      end else if (lnk.completion_ack) begin
         done_n_q <= 1'b0;
         done_a_q <= 1'b0;
         pend_ok_q <= 1'b0;
         pend_bad_q <= 1'b0;
      end else begin
         if (finish_ok || lnk.stop) pend_ok_q <= 1'b1;
         if (finish_bad) pend_bad_q <= 1'b1;
         if (cmd_ack_q && !svc_req_q && !lnk.svc_resp && !done_n_q && !done_a_q) begin
            done_a_q <= pend_bad_q;
            done_n_q <= pend_ok_q & ~pend_bad_q;
         end
      end
   end

   // Character service: request, drop once answered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         svc_req_q <= 1'b0;
         rbus_q <= 9'h000;
         rx_char <= 6'h00;
      end else if (svc_req_q && lnk.svc_resp) begin
         svc_req_q <= 1'b0;
         rx_char <= lnk.write_bus[5:0];
      end else if (svc_go && cmd_ack_q && !svc_req_q && !lnk.svc_resp && !lnk.stop &&
                   !done_n_q && !done_a_q && !pend_ok_q && !pend_bad_q) begin
         svc_req_q <= 1'b1;
         rbus_q <= {cat_pkg::cat_odd_par(svc_data), 2'b00, svc_data};
      end
   end

   // Alerts: raise only while ack is low, drop one cycle after ack
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         alert_q <= 2'b00;
         pend_q <= 2'b00;
         alert_cause <= 2'b00;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (alert_set[i]) alert_cause[i] <= 1'b1;
            else if (cause_clear) alert_cause[i] <= 1'b0;
            if (alert_q[i] && lnk.alert_ack[i]) alert_q[i] <= 1'b0;
            else if (pend_q[i] && !alert_q[i] && !lnk.alert_ack[i]) alert_q[i] <= 1'b1;
            if (alert_set[i]) pend_q[i] <= 1'b1;
            else if (pend_q[i] && !alert_q[i] && !lnk.alert_ack[i]) pend_q[i] <= 1'b0;
         end
      end
   end
endmodule // cat_adapter

/* cat_link_properties.sv */
// Timing checks on the link between channel and adapter
`timescale 1ns/1ps
module cat_link_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic operational,
   input wire logic [3:0] cmd,
   input wire logic cmd_ack,
   input wire logic done_normal,
   input wire logic done_abnormal,
   input wire logic completion_ack,
   input wire logic [1:0] device_alert,
   input wire logic [1:0] alert_ack
);
   localparam int DROP_CYC = 120;
   // Single domain, clock and reset given once
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Any sign of an unfinished operation
   wire ends = cmd_ack | done_normal | done_abnormal;
   property p_cack_hold; completion_ack && ends |=> completion_ack; endproperty
   a_cack_hold: assert property (p_cack_hold) else $error("completion ack dropped early");
   property p_cack_first; $rose(|cmd) |-> !completion_ack; endproperty
   a_cack_first: assert property (p_cack_first) else $error("command while completion ack up");
   property p_end_ans; $rose(done_normal | done_abnormal) |=> completion_ack; endproperty
   a_end_ans: assert property (p_end_ans) else $error("completion not answered");
   property p_adp_ready; $rose(completion_ack) |=> !ends; endproperty
   a_adp_ready: assert property (p_adp_ready) else $error("adapter kept end lines");
   property p_ack_hold; 1'b1 |=> (alert_ack | ~$past(alert_ack & device_alert)) == 2'b11; endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("alert ack dropped early");
   property p_ack_fall; ($past(alert_ack) & ~alert_ack & $past(device_alert)) == 2'b00; endproperty
   a_ack_fall: assert property (p_ack_fall) else $error("alert ack fell before alert");
   property p_gate; (alert_ack & ~$past(alert_ack)) != 2'b00 |-> $past(operational); endproperty
   a_gate: assert property (p_gate) else $error("alert acked while not operational");
   property p_alert_rise; (device_alert & ~$past(device_alert) & $past(alert_ack)) == 2'b00; endproperty
   a_alert_rise: assert property (p_alert_rise) else $error("alert raised during ack");
   property p_drop; $rose(alert_ack[0]) |-> ##[0:DROP_CYC] !device_alert[0]; endproperty
   a_drop: assert property (p_drop) else $error("alert held too long");
endmodule // cat_link_properties

/* tb_top.sv */
// Bench for channel and adapter joined by their link
`timescale 1ns/1ps
`include "cat_map.svh"
module tb_top;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic online = 0, finish_ok = 0, finish_bad = 0, svc_go = 0, cause_clear = 0;
   logic [5:0] svc_data = 6'h00, rx_char;
   logic [1:0] alert_set = 2'b00, alert_cause;
   logic [3:0] op_kind;
   logic [2:0] mon;
   int errors = 0, num_checks = 0, n;
   cat_if lnk_if();
   assign mon = {lnk_if.completion_ack, lnk_if.alert_ack};
   cat_channel cat_channel_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk_if));
   cat_adapter cat_adapter_inst (.pclk(pclk), .presetn(presetn), .lnk(lnk_if), .online(online),
      .finish_ok(finish_ok), .finish_bad(finish_bad), .svc_go(svc_go), .svc_data(svc_data),
      .alert_set(alert_set), .cause_clear(cause_clear), .op_kind(op_kind), .rx_char(rx_char),
      .alert_cause(alert_cause));
   cat_link_properties cat_link_properties_inst (.pclk(pclk), .presetn(presetn),
      .operational(lnk_if.operational), .cmd(lnk_if.cmd), .cmd_ack(lnk_if.cmd_ack),
      .done_normal(lnk_if.done_normal), .done_abnormal(lnk_if.done_abnormal),
      .completion_ack(lnk_if.completion_ack), .device_alert(lnk_if.device_alert), .alert_ack(lnk_if.alert_ack));
   // 20 MHz clock
   initial forever #25 pclk = ~pclk;
   task chk(input string nm, input logic [35:0] e, input logic [35:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   // APB master; waits for pready, only the watchdog ends a hang, idles one cycle after
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // Load the word buffer with an opcode and low data, then run a control word cycle
   task op(input logic [4:0] c, input logic [6:0] lo);
      apb(1, `CAT_OFF_WORD_LO, {15'h0000, c[0], 9'h000, lo});
      apb(1, `CAT_OFF_WORD_HI, {28'h000_0000, c[4:1]});
      apb(1, `CAT_OFF_CTRL, 32'h0000_0000);
      repeat (2) @(posedge pclk);
   endtask
   // Bounded wait on an ack line; running out counts as a mismatch
   task wt(input int s, input logic v);
      for (n = 0; n < 300 && mon[s] !== v; n++) @(posedge pclk);
      chk("ack line", v, mon[s]);
   endtask
   task t_regs;
      apb(0, `CAT_OFF_MODE, 32'h0000_0000);
      chk("mode reset", `CAT_MODE_RESET, rd[6:0]);
      apb(0, 12'h020, 32'h0000_0000);
      chk("slverr", 1, er);
      chk("unmapped", 0, rd);
      op(`CAT_OPC_MODE_SEL, 7'h55);
      apb(0, `CAT_OFF_MODE, 32'h0000_0000);
      chk("mode sel", 7'h55, rd[6:0]);
      apb(1, `CAT_OFF_MODE, 32'h0000_0000);
      apb(1, `CAT_OFF_COUNTER, 32'h0000_7FFE);
      op(`CAT_OPC_STEP_CNT, 7'h00);
      apb(0, `CAT_OFF_COUNTER, 32'h0000_0000);
      chk("step", 15'h7FFF, rd[14:0]);
      op(`CAT_OPC_STEP_CNT, 7'h00);
      apb(0, `CAT_OFF_COUNTER, 32'h0000_0000);
      chk("step wrap", 0, rd[14:0]);
      $display("test regs done");
   endtask
   // Finish the running command and wait out the completion handshake
   task fin(input logic bad);
      if (bad) finish_bad <= 1'b1;
      else finish_ok <= 1'b1;
      @(posedge pclk);
      finish_bad <= 1'b0;
      finish_ok <= 1'b0;
      wt(2, 1);
      wt(2, 0);
   endtask
   task t_cmd;
      op(`CAT_OPC_WRITE, 7'h00);
      chk("op kind", 4'b0010, op_kind);
      fin(0);
      op(`CAT_OPC_READ, 7'h00);
      op(`CAT_OPC_WRITE, 7'h00);
      fin(1);
      apb(0, `CAT_OFF_INT_COND, 32'h0000_0000);
      chk("seq abn", 6'h06, rd[5:0]);
      apb(1, `CAT_OFF_INT_COND, 32'h0000_003F);
      $display("test cmd done");
   endtask
   task t_alert;
      alert_set <= 2'b01;
      @(posedge pclk);
      alert_set <= 2'b00;
      repeat (20) @(posedge pclk);
      chk("gated", 0, lnk_if.alert_ack[0]);
      online <= 1'b1;
      wt(0, 1);
      wt(0, 0);
      apb(0, `CAT_OFF_INT_COND, 32'h0000_0000);
      chk("alert1", 6'h08, rd[5:0]);
      chk("cause", 2'b01, alert_cause);
      // Interrupt line lands on word bit 16
      op(`CAT_OPC_DIAG_STORE, 7'h00);
      apb(0, `CAT_OFF_WORD_LO, 32'h0000_0000);
      chk("diag store", 32'h0008_0000, rd);
      alert_set <= 2'b10;
      @(posedge pclk);
      alert_set <= 2'b00;
      repeat (20) @(posedge pclk);
      chk("busy ign", 0, lnk_if.alert_ack[1]);
      op(`CAT_OPC_INT_DONE, 7'h00);
      wt(1, 1);
      wt(1, 0);
      apb(0, `CAT_OFF_INT_COND, 32'h0000_0000);
      chk("alert2", 6'h18, rd[5:0]);
      op(`CAT_OPC_INT_DONE, 7'h00);
      apb(1, `CAT_OFF_INT_COND, 32'h0000_003F);
      cause_clear <= 1'b1;
      @(posedge pclk);
      cause_clear <= 1'b0;
      @(posedge pclk);
      chk("cause clr", 0, alert_cause);
      $display("test alert done");
   endtask
   task t_inh;
      op(`CAT_OPC_MODE_SEL, 7'h04);
      op(`CAT_OPC_WRITE, 7'h00);
      alert_set <= 2'b01;
      @(posedge pclk);
      alert_set <= 2'b00;
      wt(0, 1);
      chk("ack in cmd", 1, lnk_if.alert_ack[0]);
      wt(0, 0);
      fin(1);
      apb(0, `CAT_OFF_INT_COND, 32'h0000_0000);
      chk("inhibit", 6'h04, rd[5:0]);
      $display("test inhibit done");
   endtask
   // One write character from the assembly register, then a channel stop still gets its ack
   task t_svc;
      op(`CAT_OPC_LOAD_ASM, 7'h00);
      op(`CAT_OPC_WRITE, 7'h00);
      svc_go <= 1'b1;
      @(posedge pclk);
      svc_go <= 1'b0;
      repeat (6) @(posedge pclk);
      chk("write char", {4'(`CAT_OPC_LOAD_ASM >> 1), 2'b00}, rx_char);
      op(`CAT_OPC_STOP, 7'h00);
      wt(2, 1);
      wt(2, 0);
      $display("test svc done");
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs;
      t_cmd;
      t_alert;
      t_inh;
      t_svc;
      test_done;
   end
   // Watchdog well beyond the expected few hundred cycles
   initial begin
      #1000000;
      errors++;
      test_done;
   end
endmodule // tb_top
